/* File: rtl/adirq_core.sv */
// Implementation choice: the APB slave port.
`timescale 1ns/100ps

// Function
// RL1 - enable strobe one sets matching mask bit
// RL2 - disable strobe at 0x18 clears mask bit
// RL3 - zero bits written to strobes do nothing
// RL4 - underrun at bit 2, ready at bit 1
// RL5 - underrun sticky; ready set while accepting data
// RL6 - flag clear one clears flag and request
// RL7 - request high when flag and mask set
module adirq_core
    import adirq_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // events from the sample path, same clock domain
    input wire logic tx_underrun_evt_i,
    input wire logic tx_accept_i,
    input wire logic busy_i,
    // mask and request outputs
    output logic [ADIRQ_FIELD_W-1:0] irq_mask_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    if (ADDR_W < ADIRQ_OFS_W) begin : g_addr_check
        $error("adirq_core: ADDR_W too narrow for the register map");
    end

    // both interrupt sources must sit inside the shared field
    if (ADIRQ_BIT_TX_UNDERRUN >= ADIRQ_FIELD_W
            || ADIRQ_BIT_TX_ACCEPT >= ADIRQ_FIELD_W) begin : g_field_check
        $error("adirq_core: interrupt bit outside the field");
    end

    // busy is a live level and must never reach the request
    if (ADIRQ_IRQ_BITS[ADIRQ_BIT_BUSY] != 1'b0) begin : g_busy_check
        $error("adirq_core: busy must not be an interrupt source");
    end

    // the two sources must not share a bit position
    if (ADIRQ_BIT_TX_UNDERRUN == ADIRQ_BIT_TX_ACCEPT) begin : g_dup_check
        $error("adirq_core: interrupt sources overlap");
    end

    // the field must fit into byte lane zero, the only lane we honour
    if (ADIRQ_FIELD_W > 8) begin : g_lane_check
        $error("adirq_core: field wider than byte lane zero");
    end

    ////////////////////////////////////////////////////////////////////////////
    // register map, one aligned word each
    //
    //   enable strobe  write only, ones set mask bits
    //   disable strobe write only, ones clear mask bits
    //   mask view      read only, the mask itself
    //   flag view      read only, sticky flags plus live busy
    //   flag clear     write only, ones clear sticky flags
    //
    // a read of a write-only register returns zero without an error,
    // so software probing the map does not trap; an address outside the
    // map answers with an error and changes nothing.
    //
    // hazard: a clear of the accept flag only sticks while the sample
    // path cannot take data, because the flag is re-set on every such
    // cycle; software that wants a clean edge should mask the source.
    //
    // limitation: strobes only look at byte lane zero, so a write whose
    // lane zero strobe is off is silently dropped rather than refused.

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    // the offset field of a bus address; upper bits must be zero to hit
    function automatic logic addr_hits(
        input logic [ADDR_W-1:0] addr,
        input logic [7:0] ofs
    );
        logic [ADDR_W-1:0] full;
        full = '0;
        full[ADIRQ_OFS_W-1:0] = ofs;
        return addr == full;
    endfunction

    // any of the five registers of this block
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
        return addr_hits(addr, ADIRQ_OFS_IRQ_ENABLE_STROBE)
            || addr_hits(addr, ADIRQ_OFS_IRQ_DISABLE_STROBE)
            || addr_hits(addr, ADIRQ_OFS_IRQ_MASK_VIEW)
            || addr_hits(addr, ADIRQ_OFS_FLAG_VIEW)
            || addr_hits(addr, ADIRQ_OFS_FLAG_CLEAR_STROBE);
    endfunction

    // read data for an address; zero for write-only and unmapped words
    function automatic logic [31:0] read_word(
        input logic [ADDR_W-1:0] addr,
        input logic [ADIRQ_FIELD_W-1:0] mask,
        input logic [ADIRQ_FIELD_W-1:0] flags
    );
        logic [31:0] word;
        word = ADIRQ_RDATA_RST;
        if (addr_hits(addr, ADIRQ_OFS_IRQ_MASK_VIEW)) begin
            word = to_word_w(mask);
        end else if (addr_hits(addr, ADIRQ_OFS_FLAG_VIEW)) begin
            word = to_word_w(flags);
        end
        return word;
    endfunction

    // widen a field to a bus word, used by the read mux
    function automatic logic [31:0] to_word_w(
        input logic [ADIRQ_FIELD_W-1:0] field
    );
        logic [31:0] word;
        word = '0;
        word[ADIRQ_FIELD_W-1:0] = field;
        return word;
    endfunction

    // widen a field to a bus word with zeros above
    function automatic logic [31:0] to_word(
        input logic [ADIRQ_FIELD_W-1:0] field
    );
        logic [31:0] word;
        word = '0;
        word[ADIRQ_FIELD_W-1:0] = field;
        return word;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    adirq_regs_type regs_q;
    adirq_regs_type regs_d;

    logic [ADIRQ_FIELD_W-1:0] flag_q;
    logic [ADIRQ_FIELD_W-1:0] flag_set;
    logic [ADIRQ_FIELD_W-1:0] flag_clr;
    logic [ADIRQ_FIELD_W-1:0] wr_field;
    logic setup_phase;
    logic wr_commit;
    logic wr_en_strobe;
    logic wr_dis_strobe;
    logic wr_flag_clr;
    logic [ADIRQ_FIELD_W-1:0] flag_view;

    ////////////////////////////////////////////////////////////////////////////
    // bus phase decode

    // a setup cycle is psel without penable, whatever state we are in
    assign setup_phase = psel_i && !penable_i;

    // a write lands only on the access edge that sees pready high
    assign wr_commit = (regs_q.phase == ADIRQ_ST_ACCESS) && psel_i
        && penable_i && pwrite_i && !regs_q.slverr && pstrb_i[0];

    // only the implemented field of byte lane 0 reaches any logic
    assign wr_field = pwdata_i[ADIRQ_FIELD_W-1:0] & ADIRQ_IRQ_BITS; // RL4

    assign wr_en_strobe = wr_commit
        && addr_hits(paddr_i, ADIRQ_OFS_IRQ_ENABLE_STROBE);
    assign wr_dis_strobe = wr_commit
        && addr_hits(paddr_i, ADIRQ_OFS_IRQ_DISABLE_STROBE);
    assign wr_flag_clr = wr_commit
        && addr_hits(paddr_i, ADIRQ_OFS_FLAG_CLEAR_STROBE);

    ////////////////////////////////////////////////////////////////////////////
    // flag sources

    // underrun is caught as a pulse and held until cleared
    // ready is re-set every cycle the sample path can take data, so a
    // clear while it is still ready has no lasting effect by design
    always_comb begin
        flag_set = '0;
        flag_set[ADIRQ_BIT_TX_UNDERRUN] = tx_underrun_evt_i; // RL5
        flag_set[ADIRQ_BIT_TX_ACCEPT] = tx_accept_i; // RL5
        flag_clr = wr_flag_clr ? wr_field : '0; // RL6 RL3
    end

    adirq_flag_bank #(
        .WIDTH(ADIRQ_FIELD_W)
    ) u_flags (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .set_i(flag_set),
        .clr_i(flag_clr),
        .flag_o(flag_q)
    );

    // busy is a live level, not sticky, and never requests an interrupt
    always_comb begin
        flag_view = flag_q & ADIRQ_IRQ_BITS;
        flag_view[ADIRQ_BIT_BUSY] = busy_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state: bus phase, read capture and mask

    // read data are captured at the setup edge, so a read reports the
    // state one cycle before the access edge; this keeps prdata on a flop
    always_comb begin
        regs_d = regs_q;
        case (regs_q.phase)
            ADIRQ_ST_SETUP: begin
                if (setup_phase) begin
                    regs_d.phase = ADIRQ_ST_ACCESS;
                    regs_d.slverr = !addr_mapped(paddr_i);
                    regs_d.rdata = ADIRQ_RDATA_RST;
                    // writes leave the read word at zero
                    if (!pwrite_i) begin
                        regs_d.rdata = read_word(paddr_i, regs_q.mask,
                            flag_view); // RL4
                    end
                end
            end
            ADIRQ_ST_ACCESS: begin
                // pready is high here, so every access phase ends now
                regs_d.phase = ADIRQ_ST_SETUP;
                regs_d.slverr = 1'b0;
                regs_d.rdata = ADIRQ_RDATA_RST;
            end
            default: begin
                regs_d.phase = ADIRQ_ST_SETUP;
            end
        endcase

        // disable applied after enable; both never hit in one write
        if (wr_en_strobe) begin
            regs_d.mask = regs_q.mask | wr_field; // RL1 RL3
        end
        if (wr_dis_strobe) begin
            regs_d.mask = regs_q.mask & ~wr_field; // RL2 RL3
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            regs_q <= '{
                phase: ADIRQ_ST_SETUP,
                rdata: ADIRQ_RDATA_RST,
                slverr: 1'b0,
                mask: ADIRQ_MASK_RST // RL7
            };
        end else begin
            regs_q <= regs_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign pready_o = (regs_q.phase == ADIRQ_ST_ACCESS);
    assign pslverr_o = (regs_q.phase == ADIRQ_ST_ACCESS) && regs_q.slverr;
    assign prdata_o = regs_q.rdata;
    // the mask leaves on its flop, so a consumer sees no decode glitch
    assign irq_mask_o = regs_q.mask;

    // level request straight from flops; drops the cycle after a clear
    assign irq_o = |(flag_q & regs_q.mask & ADIRQ_IRQ_BITS); // RL7 RL6

endmodule

/* File: rtl/adirq_pkg.sv */
package adirq_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets, every one a multiple of four
    localparam int ADIRQ_OFS_W = 8;
    localparam logic [7:0] ADIRQ_OFS_IRQ_ENABLE_STROBE = 8'h14;
    localparam logic [7:0] ADIRQ_OFS_IRQ_DISABLE_STROBE = 8'h18;
    localparam logic [7:0] ADIRQ_OFS_IRQ_MASK_VIEW = 8'h1c;
    localparam logic [7:0] ADIRQ_OFS_FLAG_VIEW = 8'h20;
    localparam logic [7:0] ADIRQ_OFS_FLAG_CLEAR_STROBE = 8'h24;

    ////////////////////////////////////////////////////////////////////////////
    // field layout, shared by strobes, mask, flags and flag clear
    localparam int ADIRQ_FIELD_W = 3;
    localparam int ADIRQ_BIT_BUSY = 0;
    localparam int ADIRQ_BIT_TX_ACCEPT = 1;
    localparam int ADIRQ_BIT_TX_UNDERRUN = 2;
    localparam logic [2:0] ADIRQ_IRQ_BITS = 3'h6;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [2:0] ADIRQ_MASK_RST = 3'h0;
    localparam logic [2:0] ADIRQ_FLAG_RST = 3'h0;
    localparam logic [31:0] ADIRQ_RDATA_RST = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // bus slave phase
    typedef enum logic [0:0] {
        ADIRQ_ST_SETUP = 1'b0,
        ADIRQ_ST_ACCESS = 1'b1
    } adirq_phase_type;

    typedef struct packed {
        adirq_phase_type phase;
        logic [31:0] rdata;
        logic slverr;
        logic [2:0] mask;
    } adirq_regs_type;

    typedef struct packed {
        logic [2:0] flags;
    } adirq_flag_state_type;

endpackage

/* File: rtl/adirq_flag_bank.sv */
`timescale 1ns/100ps

// sticky flag bank: a set and a write-one clear per bit
module adirq_flag_bank
    import adirq_pkg::*;
#(
    parameter int WIDTH = ADIRQ_FIELD_W
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] set_i,
    input wire logic [WIDTH-1:0] clr_i,
    output logic [WIDTH-1:0] flag_o
);

    if (WIDTH != ADIRQ_FIELD_W) begin : g_width_check
        $error("adirq_flag_bank: WIDTH must match the field layout");
    end

    adirq_flag_state_type state_q;
    adirq_flag_state_type state_d;

    ////////////////////////////////////////////////////////////////////////////
    // a set arriving with its clear wins, so no event is lost
    always_comb begin
        state_d = state_q;
        state_d.flags = (state_q.flags & ~clr_i) | set_i; // RL5 RL6
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= '{flags: ADIRQ_FLAG_RST};
        end else begin
            state_q <= state_d;
        end
    end

    assign flag_o = state_q.flags;

endmodule

/* File: verification/adirq_props.sv */
`timescale 1ns/100ps
// mask and request relations seen at the ports of the mask block
module adirq_props
    import adirq_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic tx_underrun_evt_i,
    input wire logic tx_accept_i,
    input wire logic busy_i,
    input wire logic [ADIRQ_FIELD_W-1:0] irq_mask_o,
    input wire logic irq_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    logic acc, wr, w_en, w_dis;
    logic [2:0] wd;
    // writes only act through byte lane zero, so the strobe gates them
    assign acc = psel_i && penable_i && pready_o;
    assign wr = acc && pwrite_i && pstrb_i[0];
    assign w_en = wr && paddr_i == ADIRQ_OFS_IRQ_ENABLE_STROBE;
    assign w_dis = wr && paddr_i == ADIRQ_OFS_IRQ_DISABLE_STROBE;
    assign wd = pwdata_i[2:0] & 3'h6;
    a_enable_sets: assert property (w_en |=>
        irq_mask_o == ($past(irq_mask_o) | $past(wd))) else $error("enable");
    a_disable_clears: assert property (w_dis |=>
        irq_mask_o == ($past(irq_mask_o) & ~$past(wd))) else $error("disable");
    a_mask_steady: assert property (!(w_en || w_dis) |=>
        $stable(irq_mask_o)) else $error("mask moved without strobe");
    a_bit0_unused: assert property (irq_mask_o[0] == 1'b0)
        else $error("mask bit 0 set");
    a_irq_needs_mask: assert property (irq_o |-> irq_mask_o != 3'h0)
        else $error("request with empty mask");
    a_underrun_raises: assert property (tx_underrun_evt_i && irq_mask_o[2]
        && !w_dis |=> irq_o) else $error("underrun request missing");
    a_accept_raises: assert property (tx_accept_i && irq_mask_o[1]
        && !w_dis |=> irq_o) else $error("accept request missing");
    a_clear_drops: assert property (wr && wd == 3'h6
        && paddr_i == ADIRQ_OFS_FLAG_CLEAR_STROBE && !tx_underrun_evt_i
        && !tx_accept_i |=> !irq_o) else $error("request kept after clear");
    a_mask_readback: assert property (acc && !pwrite_i
        && paddr_i == ADIRQ_OFS_IRQ_MASK_VIEW |-> prdata_o == 32'(irq_mask_o))
        else $error("mask read wrong");
    c_en: cover property (w_en && wd != 3'h0);
    c_dis: cover property (w_dis && wd != 3'h0);
    c_irq: cover property ($rose(irq_o));
endmodule
bind adirq_core adirq_props #(.ADDR_W(ADDR_W)) i_props (.*);

/* File: verification/tb_audio_dac_irq_mask.sv */
`timescale 1ns/100ps
// drives the mask block over its register port and event inputs
module tb_audio_dac_irq_mask;
    import adirq_pkg::*;
    logic mclk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic tx_underrun_evt_i = 0, tx_accept_i = 0, busy_i = 0;
    logic [7:0] paddr_i = 8'h00, a;
    logic [31:0] pwdata_i = 32'h0, prdata_o, s = 32'h2ace4523;
    logic [3:0] pstrb_i = 4'hf, stb = 4'hf;
    logic pready_o, pslverr_o, irq_o;
    logic [2:0] irq_mask_o, m = 3'h0;
    logic [32:0] expq[$];
    int n_fail = 0, checks = 0;
    adirq_core #(.ADDR_W(8)) i_dut (.*);
    initial forever #4 mclk_i = ~mclk_i;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    task automatic close_out();
        if (expq.size() != 0) n_fail++;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp_irq(input logic e);
        checks++;
        if (irq_o !== e) begin
            n_fail++;
            $display("mismatch irq_o exp %b got %b", e, irq_o);
        end
    endtask
    // one transfer; reads leave their expected word in the queue
    task automatic apb(input logic w, input logic [7:0] ad,
        input logic [31:0] d, input logic [32:0] e);
        int n;
        @(posedge mclk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= ad;
        pwdata_i <= d;
        pstrb_i <= stb;
        if (!w) expq.push_back(e);
        @(posedge mclk_i);
        penable_i <= 1'b1;
        n = 0;
        #1;
        while (pready_o !== 1'b1) begin
            if (++n > 16) begin
                n_fail++;
                close_out();
            end
            @(posedge mclk_i);
            #1;
        end
        @(posedge mclk_i);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    // read answers stand one cycle, so look mid-cycle while settled
    always @(negedge mclk_i) begin
        if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i) begin
            checks++;
            if (expq.size() == 0) n_fail++;
            else if ({pslverr_o, prdata_o} !== expq[0]) begin
                n_fail++;
                $display("mismatch prdata exp %h got %h", expq[0],
                    {pslverr_o, prdata_o});
            end
            if (expq.size() != 0) void'(expq.pop_front());
        end
    end
    initial begin
        repeat (5) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        apb(0, ADIRQ_OFS_IRQ_MASK_VIEW, 0, 33'h0);
        apb(0, ADIRQ_OFS_IRQ_ENABLE_STROBE, 0, 33'h0);
        apb(0, ADIRQ_OFS_IRQ_DISABLE_STROBE, 0, 33'h0);
        apb(0, 8'h30, 0, {1'b1, 32'h0});
        // random strobes, lane zero sometimes off so the write is void
        for (int i = 0; i < 24; i++) begin
            s = xs(s);
            stb = s[7:4];
            a = s[8] ? ADIRQ_OFS_IRQ_DISABLE_STROBE
                : ADIRQ_OFS_IRQ_ENABLE_STROBE;
            if (stb[0] && s[8]) m = m & ~(s[14:12] & 3'h6);
            else if (stb[0]) m = m | (s[14:12] & 3'h6);
            apb(1, a, s >> 12, 33'h0);
            stb = 4'hf;
            apb(0, ADIRQ_OFS_IRQ_MASK_VIEW, 0, {30'h0, m});
        end
        apb(1, ADIRQ_OFS_IRQ_ENABLE_STROBE, 32'h6, 33'h0);
        busy_i <= 1'b1;
        tx_underrun_evt_i <= 1'b1;
        @(posedge mclk_i);
        tx_underrun_evt_i <= 1'b0;
        #1 cmp_irq(1'b1);
        apb(0, ADIRQ_OFS_FLAG_VIEW, 0, 33'h5);
        apb(1, ADIRQ_OFS_FLAG_CLEAR_STROBE, 32'h6, 33'h0);
        #1 cmp_irq(1'b0);
        apb(0, ADIRQ_OFS_FLAG_VIEW, 0, 33'h1);
        @(posedge mclk_i);
        tx_accept_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        #1 cmp_irq(1'b1);
        apb(1, 8'h30, 32'h6, 33'h0);
        apb(0, ADIRQ_OFS_IRQ_MASK_VIEW, 0, 33'h6);
        apb(1, ADIRQ_OFS_IRQ_DISABLE_STROBE, 32'h2, 33'h0);
        #1 cmp_irq(1'b0);
        @(posedge mclk_i);
        tx_accept_i <= 1'b0;
        @(posedge mclk_i);
        apb(1, ADIRQ_OFS_FLAG_CLEAR_STROBE, 32'h2, 33'h0);
        apb(0, ADIRQ_OFS_FLAG_VIEW, 0, 33'h1);
        close_out();
    end
endmodule
